//--- inc/fpo_defs.svh
// fpo constants: command codes, address fields, timing figures
`ifndef FPO_DEFS_SVH
`define FPO_DEFS_SVH

`define FPO_CMD_CLEAR_FLAGS      8'h30
`define FPO_CMD_DEEP_SLEEP       8'hB9
`define FPO_CMD_WAKE_ID          8'hAB
`define FPO_CMD_RESET_ARM        8'h66
`define FPO_CMD_RESET_GO         8'h99
`define FPO_CMD_SECREG_READ      8'h48
`define FPO_CMD_SECREG_PROG      8'h42
`define FPO_CMD_WRITE_LATCH_SET  8'h06

`define FPO_SEL_REG1             2'h1
`define FPO_SEL_REG2             2'h2
`define FPO_SEL_PAD              2'h0
`define FPO_SECREG_BYTES         1024
`define FPO_ERASED_BYTE          8'hFF
`define FPO_MAX_PROG_BYTES       9'h100
`define FPO_ADDR3_BITS           6'h18
`define FPO_ADDR4_BITS           6'h20
`define FPO_ID_DUMMY_BITS        6'h18
`define FPO_RD_DUMMY_BITS        6'h08
`define FPO_BYTE_LAST            6'h07
`define FPO_OUT_LAST             3'h7
`define FPO_ID_CODE              8'h5A
`define FPO_SYNC_IDLE            3'h4
`define FPO_TIMER_BITS           24

`define FPO_CLK_PERIOD_NS        8
`define FPO_SLEEP_ENTRY_NS       3000
`define FPO_WAKE_NS              3000
`define FPO_IDENTIFY_WAKE_NS     2000
`define FPO_PAGE_PROGRAM_NS      100000
`define FPO_HOST_HALF_CYC        10
`define FPO_CYC_MIN(ns)          (((ns) + `FPO_CLK_PERIOD_NS - 1) / `FPO_CLK_PERIOD_NS)

`endif

//--- inc/fpo_pkg.sv
// fpo types shared by both ends
package fpo_pkg;
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_WDATA, PH_RDATA, PH_IGNORE} fpo_phase_t;
  typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_TRAIL, HS_GUARD} fpo_hstate_t;
endpackage

//--- inc/fpo_link_if.sv
// fpo serial link between host and flash command end
`timescale 1ns/1ps
`default_nettype none
interface fpo_link_if;
  logic csN;
  logic sclk;
  logic mosi;
  logic miso;
  logic misoOe;
  // line level seen on the data-out wire, pulled high when undriven
  wire  misoLine = misoOe ? miso : 1'b1;
  modport dev (input csN, input sclk, input mosi, output miso, output misoOe);
  modport host (output csN, output sclk, output mosi, input miso, input misoOe, input misoLine);
endinterface
`default_nettype wire

//--- core/fpo_device.sv
// flash end: clear flags, deep sleep, identifier, security register read and program
`timescale 1ns/1ps
`default_nettype none
`include "fpo_defs.svh"
// Overview of operation
// - clear-flags command resets program and erase errors
// - clear-flags needs no write latch, keeps it
// - deep sleep only by command, blocks writes
// - asleep: only wake-identify or two-step reset
// - chip select high, idle: standby, not sleep
// - reset is power-up: always wake in standby
// - sleep only if select rises after bit eight
// - sleep command rejected while a cycle runs
// - wake code alone waits wake delay
// - identifier after three dummies, falling edge, msb
// - identifier repeats until chip select rises
// - identify from sleep waits shorter wake delay
// - wake-identify ignored while write in progress
// - read: code, address, dummy, then data out
// - read address increments, low ten bits wrap
// - bits 13-12 select register, 9-0 byte
// - three address bytes, four in wide mode
// - program takes one to 256 data bytes
// - program needs write latch set first
// - program cycle after select rise, latch clears
// - locked register ignores program commands
module fpo_device
  import fpo_pkg::*;
#(
  parameter logic [7:0] ID_CODE         = `FPO_ID_CODE,  // arbitrary value
  parameter int         SLEEP_ENTRY_CYC = `FPO_CYC_MIN(`FPO_SLEEP_ENTRY_NS),
  parameter int         WAKE_CYC        = `FPO_CYC_MIN(`FPO_WAKE_NS),
  parameter int         IDWAKE_CYC      = `FPO_CYC_MIN(`FPO_IDENTIFY_WAKE_NS),
  parameter int         PROGRAM_CYC     = `FPO_CYC_MIN(`FPO_PAGE_PROGRAM_NS)
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // serial link
  fpo_link_if.dev         link,
  // configuration and array events
  input  wire logic       fourByteMode,
  input  wire logic [1:0] lockBits,
  input  wire logic       programErrorSet,
  input  wire logic       eraseErrorSet,
  // status
  output logic            writeInProgress,
  output logic            writeLatch,
  output logic            programError,
  output logic            eraseError,
  output logic            deepSleep,
  output logic            standby,
  output logic            delayActive
);
  localparam int TMAX = (1 << `FPO_TIMER_BITS) - 1;
  localparam logic [`FPO_TIMER_BITS-1:0] T_SLEEP  = `FPO_TIMER_BITS'(SLEEP_ENTRY_CYC);
  localparam logic [`FPO_TIMER_BITS-1:0] T_WAKE   = `FPO_TIMER_BITS'(WAKE_CYC);
  localparam logic [`FPO_TIMER_BITS-1:0] T_IDWAKE = `FPO_TIMER_BITS'(IDWAKE_CYC);
  localparam logic [`FPO_TIMER_BITS-1:0] T_PROG   = `FPO_TIMER_BITS'(PROGRAM_CYC);
  localparam logic [`FPO_TIMER_BITS-1:0] T_ONE    = `FPO_TIMER_BITS'(1);

  generate
    if (SLEEP_ENTRY_CYC < 1 || WAKE_CYC < 1 || IDWAKE_CYC < 1 || PROGRAM_CYC < 1 ||
        SLEEP_ENTRY_CYC > TMAX || WAKE_CYC > TMAX || IDWAKE_CYC > TMAX || PROGRAM_CYC > TMAX) begin : g_chk
      $error("fpo_device: delay counts out of range");
    end
  endgenerate

  // link synchronisers: cs, sclk, data in
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic       csQ;
  logic       sclkQ;
  always_ff @(posedge clk) begin
    if (reset) begin
      syncA <= `FPO_SYNC_IDLE;
      syncB <= `FPO_SYNC_IDLE;
      csQ   <= 1'b1;
      sclkQ <= 1'b0;
    end else begin
      syncA <= {link.csN, link.sclk, link.mosi};
      syncB <= syncA;
      csQ   <= syncB[2];
      sclkQ <= syncB[1];
    end
  end

  wire csHigh   = syncB[2];
  wire siNow    = syncB[0];
  wire sclkRise = ~csHigh & syncB[1] & ~sclkQ;
  wire sclkFall = ~csHigh & ~syncB[1] & sclkQ;
  wire csRise   = csHigh & ~csQ;

  fpo_phase_t  phase;
  fpo_phase_t  decPhase;
  logic [7:0]  cmd;
  logic        cmdValid;
  logic        decValid;
  logic        extra;
  logic        isId;
  logic        selValid;
  logic        progOk;
  logic        progAny;
  logic        regTwo;
  logic        resetArm;
  logic        dlyToSleep;
  logic        misoOut;
  logic        misoOe;
  logic [5:0]  cnt;
  logic [5:0]  addrBits;
  logic [5:0]  dummyBits;
  logic [31:0] shiftIn;
  logic [9:0]  addr;
  logic [8:0]  byteCnt;
  logic [2:0]  outBit;
  logic [`FPO_TIMER_BITS-1:0] progCnt;
  logic [`FPO_TIMER_BITS-1:0] dlyCnt;
  logic [7:0]  mem [0:2*`FPO_SECREG_BYTES-1];

  assign link.miso   = misoOut;
  assign link.misoOe = misoOe;

  wire [31:0] nextShift = {shiftIn[30:0], siNow};
  wire [7:0]  cmdNow    = nextShift[7:0];
  wire [1:0]  selNow    = nextShift[13:12];
  wire        sleepCmd  = cmdNow == `FPO_CMD_WAKE_ID || cmdNow == `FPO_CMD_RESET_ARM ||
                          cmdNow == `FPO_CMD_RESET_GO;
  wire        acceptCmd = ~delayActive & (~deepSleep | sleepCmd);
  wire        selOk     = nextShift[11:10] == `FPO_SEL_PAD &&
                          (selNow == `FPO_SEL_REG1 || selNow == `FPO_SEL_REG2);
  wire        lockHit   = (selNow == `FPO_SEL_REG2) ? lockBits[1] : lockBits[0];
  wire [10:0] memIdx    = {regTwo, addr};
  wire [7:0]  rdByte    = selValid ? mem[memIdx] : `FPO_ERASED_BYTE;
  wire [7:0]  outByte   = isId ? ID_CODE : rdByte;
  wire        byteDone  = sclkRise && phase == PH_WDATA && cnt == `FPO_BYTE_LAST;
  wire        doWrite   = byteDone & progOk & (byteCnt != `FPO_MAX_PROG_BYTES);
  wire        oneByte   = csRise & cmdValid & ~extra & (phase == PH_IGNORE);
  wire        wakeOnly  = csRise && cmdValid && cmd == `FPO_CMD_WAKE_ID && phase == PH_DUMMY && cnt == 6'h00;
  wire        idWake    = csRise && cmdValid && cmd == `FPO_CMD_WAKE_ID && phase == PH_RDATA;
  wire        startProg = csRise && cmdValid && cmd == `FPO_CMD_SECREG_PROG && progAny;
  wire        sleepGo   = oneByte && cmd == `FPO_CMD_DEEP_SLEEP && ~writeInProgress && ~deepSleep;
  wire        softReset = oneByte && cmd == `FPO_CMD_RESET_GO && resetArm;
  wire        clearGo   = oneByte && cmd == `FPO_CMD_CLEAR_FLAGS;
  wire        latchGo   = oneByte && cmd == `FPO_CMD_WRITE_LATCH_SET && ~writeInProgress;

  // command decode on the eighth bit
  always_comb begin
    decValid = acceptCmd;
    unique case (cmdNow)
      `FPO_CMD_SECREG_READ,
      `FPO_CMD_SECREG_PROG: decPhase = PH_ADDR;
      `FPO_CMD_WAKE_ID:     decPhase = PH_DUMMY;
      default:              decPhase = PH_IGNORE;
    endcase
    if (cmdNow == `FPO_CMD_WAKE_ID && writeInProgress) begin
      decValid = 1'b0;
    end
    if (!decValid) begin
      decPhase = PH_IGNORE;
    end
  end

  // frame sequencer, restarted by chip select high
  always_ff @(posedge clk) begin
    if (reset || csHigh) begin
      phase    <= PH_CMD;
      cnt      <= 6'h00;
      extra    <= 1'b0;
      cmdValid <= 1'b0;
      progAny  <= 1'b0;
      byteCnt  <= 9'h000;
      outBit   <= 3'h0;
      misoOe   <= 1'b0;
      misoOut  <= 1'b0;
      if (reset) begin
        cmd       <= 8'h00;
        shiftIn   <= 32'h0000_0000;
        addr      <= 10'h000;
        regTwo    <= 1'b0;
        selValid  <= 1'b0;
        progOk    <= 1'b0;
        isId      <= 1'b0;
        addrBits  <= `FPO_ADDR3_BITS;
        dummyBits <= `FPO_RD_DUMMY_BITS;
      end
    end else if (sclkRise) begin
      shiftIn <= nextShift;
      cnt     <= cnt + 6'h01;
      unique case (phase)
        PH_CMD: if (cnt == `FPO_BYTE_LAST) begin
          cmd       <= cmdNow;
          cmdValid  <= decValid;
          phase     <= decPhase;
          cnt       <= 6'h00;
          isId      <= cmdNow == `FPO_CMD_WAKE_ID;
          dummyBits <= (cmdNow == `FPO_CMD_WAKE_ID) ? `FPO_ID_DUMMY_BITS : `FPO_RD_DUMMY_BITS;
          addrBits  <= fourByteMode ? `FPO_ADDR4_BITS : `FPO_ADDR3_BITS;
        end
        PH_ADDR: if (cnt == addrBits - 6'h01) begin
          addr     <= nextShift[9:0];
          regTwo   <= selNow == `FPO_SEL_REG2;
          selValid <= selOk;
          progOk   <= selOk & ~lockHit & writeLatch & ~writeInProgress;
          phase    <= (cmd == `FPO_CMD_SECREG_READ) ? PH_DUMMY : PH_WDATA;
          cnt      <= 6'h00;
        end
        PH_DUMMY: if (cnt == dummyBits - 6'h01) begin
          phase <= PH_RDATA;
          cnt   <= 6'h00;
        end
        PH_WDATA: if (cnt == `FPO_BYTE_LAST) begin
          cnt <= 6'h00;
          if (doWrite) begin
            byteCnt <= byteCnt + 9'h001;
            progAny <= 1'b1;
            addr    <= addr + 10'h001;
          end
        end
        PH_RDATA:  cnt <= 6'h00;
        PH_IGNORE: extra <= 1'b1;
      endcase
    end else if (sclkFall && phase == PH_RDATA) begin
      misoOe  <= 1'b1;
      misoOut <= outByte[`FPO_OUT_LAST - outBit];
      outBit  <= outBit + 3'h1;
      if (outBit == `FPO_OUT_LAST && !isId) begin
        addr <= addr + 10'h001;
      end
    end
  end

  // security register storage, programmed bits only go to zero
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 2*`FPO_SECREG_BYTES; i++) begin
        mem[i] <= `FPO_ERASED_BYTE;
      end
    end else if (doWrite) begin
      mem[memIdx] <= mem[memIdx] & nextShift[7:0];
    end
  end

  // write latch, error flags, reset arming
  always_ff @(posedge clk) begin
    if (reset) begin
      writeLatch   <= 1'b0;
      programError <= 1'b0;
      eraseError   <= 1'b0;
      resetArm     <= 1'b0;
    end else begin
      if (latchGo && !deepSleep) begin
        writeLatch <= 1'b1;
      end else if (startProg || softReset) begin
        writeLatch <= 1'b0;
      end
      programError <= programErrorSet | (programError & ~clearGo);
      eraseError   <= eraseErrorSet | (eraseError & ~clearGo);
      if (oneByte) begin
        resetArm <= cmd == `FPO_CMD_RESET_ARM;
      end else if (csRise && cmdValid) begin
        resetArm <= 1'b0;
      end
    end
  end

  // program cycle timer
  always_ff @(posedge clk) begin
    if (reset) begin
      progCnt         <= '0;
      writeInProgress <= 1'b0;
    end else if (startProg) begin
      progCnt         <= T_PROG;
      writeInProgress <= 1'b1;
    end else if (progCnt == T_ONE) begin
      progCnt         <= '0;
      writeInProgress <= 1'b0;
    end else if (progCnt != '0) begin
      progCnt <= progCnt - T_ONE;
    end
  end

  // sleep entry and wake delays
  always_ff @(posedge clk) begin
    if (reset) begin
      dlyCnt      <= '0;
      dlyToSleep  <= 1'b0;
      delayActive <= 1'b0;
      deepSleep   <= 1'b0;
    end else if (softReset) begin
      dlyCnt      <= '0;
      delayActive <= 1'b0;
      deepSleep   <= 1'b0;
    end else if (sleepGo) begin
      dlyCnt      <= T_SLEEP;
      dlyToSleep  <= 1'b1;
      delayActive <= 1'b1;
    end else if (deepSleep && (wakeOnly || idWake)) begin
      dlyCnt      <= wakeOnly ? T_WAKE : T_IDWAKE;
      dlyToSleep  <= 1'b0;
      delayActive <= 1'b1;
    end else if (dlyCnt == T_ONE) begin
      dlyCnt      <= '0;
      delayActive <= 1'b0;
      deepSleep   <= dlyToSleep;
    end else if (dlyCnt != '0) begin
      dlyCnt <= dlyCnt - T_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      standby <= 1'b0;
    end else begin
      standby <= csHigh & ~writeInProgress & ~deepSleep & ~delayActive;
    end
  end
endmodule
`default_nettype wire

//--- core/fpo_host.sv
// host end: issues one framed transfer of tx and rx bytes, then a guard time
`timescale 1ns/1ps
`default_nettype none
`include "fpo_defs.svh"
module fpo_host
  import fpo_pkg::*;
#(
  parameter int HALF_CYC = `FPO_HOST_HALF_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // serial link
  fpo_link_if.host         link,
  // request
  input  wire logic        start,
  input  wire logic [9:0]  txLen,
  input  wire logic [9:0]  rxLen,
  input  wire logic [23:0] guardCycles,
  input  wire logic [7:0]  txByte,
  // answer
  output logic             busy,
  output logic             txTake,
  output logic [7:0]       rxByte,
  output logic             rxValid,
  output logic             done
);
  generate
    if (HALF_CYC < 4 || HALF_CYC > 255) begin : g_chk
      $error("fpo_host: HALF_CYC must be 4..255");
    end
  endgenerate
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  fpo_hstate_t state;
  logic        csN;
  logic        sclk;
  logic        mosi;
  logic        misoS1;
  logic        misoS2;
  logic [7:0]  halfCnt;
  logic [2:0]  bitIdx;
  logic [9:0]  txLeft;
  logic [9:0]  rxLeft;
  logic [7:0]  txShift;
  logic [7:0]  rxShift;
  logic [23:0] guard;

  assign link.csN  = csN;
  assign link.sclk = sclk;
  assign link.mosi = mosi;

  wire halfEnd  = halfCnt == HALF_LAST;
  wire byteEnd  = bitIdx == `FPO_OUT_LAST;
  wire inTx     = txLeft != 10'h000;
  wire lastByte = (txLeft == 10'h001 && rxLeft == 10'h000) || (txLeft == 10'h000 && rxLeft == 10'h001);
  wire [7:0] rxNext = {rxShift[6:0], misoS2};

  always_ff @(posedge clk) begin
    if (reset) begin
      misoS1 <= 1'b1;
      misoS2 <= 1'b1;
    end else begin
      misoS1 <= link.misoLine;
      misoS2 <= misoS1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state   <= HS_IDLE;
      csN     <= 1'b1;
      sclk    <= 1'b0;
      mosi    <= 1'b0;
      busy    <= 1'b0;
      txTake  <= 1'b0;
      rxValid <= 1'b0;
      rxByte  <= 8'h00;
      done    <= 1'b0;
      halfCnt <= 8'h00;
      bitIdx  <= 3'h0;
      txLeft  <= 10'h000;
      rxLeft  <= 10'h000;
      txShift <= 8'h00;
      rxShift <= 8'h00;
      guard   <= 24'h00_0000;
    end else begin
      txTake  <= 1'b0;
      rxValid <= 1'b0;
      done    <= 1'b0;
      halfCnt <= halfCnt + 8'h01;
      unique case (state)
        HS_IDLE: if (start) begin
          state   <= HS_LOW;
          busy    <= 1'b1;
          csN     <= 1'b0;
          txShift <= txByte;
          txTake  <= 1'b1;
          txLeft  <= txLen;
          rxLeft  <= rxLen;
          guard   <= guardCycles;
          bitIdx  <= 3'h0;
          halfCnt <= 8'h00;
        end
        HS_LOW: begin
          mosi <= inTx & txShift[7];
          if (halfEnd) begin
            sclk    <= 1'b1;
            halfCnt <= 8'h00;
            state   <= HS_HIGH;
          end
        end
        HS_HIGH: if (halfEnd) begin
          sclk    <= 1'b0;
          halfCnt <= 8'h00;
          bitIdx  <= bitIdx + 3'h1;
          rxShift <= rxNext;
          txShift <= {txShift[6:0], 1'b0};
          state   <= (byteEnd && lastByte) ? HS_TRAIL : HS_LOW;
          if (byteEnd && inTx) begin
            txLeft <= txLeft - 10'h001;
            if (txLeft != 10'h001) begin
              txShift <= txByte;
              txTake  <= 1'b1;
            end
          end else if (byteEnd) begin
            rxLeft  <= rxLeft - 10'h001;
            rxByte  <= rxNext;
            rxValid <= 1'b1;
          end
        end
        HS_TRAIL: if (halfEnd) begin
          csN     <= 1'b1;
          mosi    <= 1'b0;
          halfCnt <= 8'h00;
          state   <= HS_GUARD;
        end
        HS_GUARD: begin
          halfCnt <= HALF_LAST;
          if (halfEnd && guard == 24'h00_0000) begin
            state <= HS_IDLE;
            busy  <= 1'b0;
            done  <= 1'b1;
          end else if (halfEnd) begin
            guard <= guard - 24'h00_0001;
          end else begin
            halfCnt <= halfCnt + 8'h01;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- test/fpo_checker.sv
// fpo assertions on the link and the flash end status
`timescale 1ns/1ps
`default_nettype none
module fpo_checker #(
  parameter int PROGRAM_CYC = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link
  input wire logic csN,
  input wire logic sclk,
  input wire logic miso,
  input wire logic misoOe,
  // flash end status
  input wire logic writeInProgress,
  input wire logic writeLatch,
  input wire logic deepSleep,
  input wire logic standby,
  input wire logic delayActive
);
  logic [15:0] wipRun;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // length of the running program cycle
  always_ff @(posedge clk) begin
    wipRun <= (reset || !writeInProgress) ? 16'h0000 : wipRun + 16'h0001;
  end

  sequence progStart;
    $rose(writeInProgress);
  endsequence
  sequence sleepStart;
    $rose(deepSleep);
  endsequence
  sequence deselected;
    csN [*6];
  endsequence

  standby_not_asleep_a: assert property (standby |-> !deepSleep)
    else $error("standby and deep sleep together");
  sleep_blocks_writes_a: assert property (deepSleep |-> !$rose(writeLatch) && !$rose(writeInProgress))
    else $error("write accepted in deep sleep");
  sleep_after_delay_a: assert property (sleepStart |-> $past(delayActive) && !writeInProgress)
    else $error("deep sleep entered without entry delay");
  delay_not_busy_a: assert property (delayActive |-> !writeInProgress)
    else $error("delay started during a program cycle");
  prog_needs_latch_a: assert property (progStart |-> $past(writeLatch))
    else $error("program cycle without write latch");
  latch_drops_a: assert property (progStart |-> !writeLatch && csN)
    else $error("latch kept or cycle started inside frame");
  prog_length_a: assert property ($fell(writeInProgress) |-> wipRun >= PROGRAM_CYC && wipRun <= PROGRAM_CYC + 1)
    else $error("program cycle length wrong");
  out_release_a: assert property (deselected |-> !misoOe)
    else $error("data out driven while deselected");
  delay_quiet_a: assert property (delayActive && $past(delayActive) |-> !standby)
    else $error("standby during a delay");
  out_on_fall_a: assert property (misoOe && $past(misoOe) && $changed(miso) |-> !sclk)
    else $error("data out changed while clock high");
endmodule
`default_nettype wire

//--- test/flash_power_otp_commands_bench.sv
// fpo bench: host end drives the flash end over the link
`timescale 1ns/1ps
`default_nettype none
module flash_power_otp_commands_bench
  import fpo_pkg::*;
;
  localparam int         SLP  = 30;
  localparam int         WAKE = 250;
  localparam int         IDW  = 60;
  localparam int         PROG = 600;
  localparam int         GRD  = 100;
  localparam logic [7:0] ID   = 8'h3C;  // arbitrary value
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        start = 1'b0;
  logic [9:0]  txLen = 10'h001;
  logic [9:0]  rxLen = 10'h000;
  logic [23:0] guardCycles = 24'h000000;
  logic [7:0]  txByte = 8'h00;
  logic        fourByteMode = 1'b0;
  logic [1:0]  lockBits = 2'h0;
  logic        programErrorSet = 1'b0;
  logic        eraseErrorSet = 1'b0;
  logic        busy, txTake, rxValid, done;
  logic [7:0]  rxByte;
  logic        writeInProgress, writeLatch, programError, eraseError;
  logic        deepSleep, standby, delayActive;
  logic [7:0]  rx[$];
  int          checks = 0;
  int          miscompares = 0;

  always #4 clk = ~clk;

  fpo_link_if link ();
  fpo_host #(.HALF_CYC(10)) fpo_host_i (.clk(clk), .reset(reset), .link(link), .start(start),
    .txLen(txLen), .rxLen(rxLen), .guardCycles(guardCycles), .txByte(txByte), .busy(busy),
    .txTake(txTake), .rxByte(rxByte), .rxValid(rxValid), .done(done));
  fpo_device #(.ID_CODE(ID), .SLEEP_ENTRY_CYC(SLP), .WAKE_CYC(WAKE), .IDWAKE_CYC(IDW), .PROGRAM_CYC(PROG))
    fpo_device_i (.clk(clk), .reset(reset), .link(link), .fourByteMode(fourByteMode), .lockBits(lockBits),
    .programErrorSet(programErrorSet), .eraseErrorSet(eraseErrorSet), .writeInProgress(writeInProgress),
    .writeLatch(writeLatch), .programError(programError), .eraseError(eraseError),
    .deepSleep(deepSleep), .standby(standby), .delayActive(delayActive));
  fpo_checker #(.PROGRAM_CYC(PROG)) fpo_checker_i (.clk(clk), .reset(reset), .csN(link.csN),
    .sclk(link.sclk), .miso(link.miso), .misoOe(link.misoOe), .writeInProgress(writeInProgress),
    .writeLatch(writeLatch), .deepSleep(deepSleep), .standby(standby), .delayActive(delayActive));

  task automatic miss(input string m);
    miscompares++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) miss(m);
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) miss(m);
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one framed transfer; read bytes land in rx
  task automatic xfer(input logic [7:0] tx[$], input int nrx, input int g);
    int k;
    int n;
    k = 1;
    n = 0;
    rx = {};
    txByte      <= tx[0];
    txLen       <= 10'(tx.size());
    rxLen       <= 10'(nrx);
    guardCycles <= 24'(g);
    start       <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      if (txTake === 1'b1) begin
        txByte <= (k < tx.size()) ? tx[k] : 8'h00;
        k++;
      end
      if (rxValid === 1'b1) rx.push_back(rxByte);
    end while (done !== 1'b1 && n < 20000);
    if (n >= 20000) miss("host transfer hung");
  endtask
  task automatic cmd(input logic [7:0] c);
    xfer({c}, 0, GRD);
  endtask
  task automatic expect_rx(input logic [7:0] e[$]);
    foreach (e[i]) cmp_byte(rx[i], e[i], "read byte wrong");
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (writeInProgress !== 1'b0 && n < 2 * PROG) begin
      @(posedge clk);
      n++;
    end
    cmp_bit(writeInProgress, 1'b0, "program cycle never ended");
  endtask

  task automatic s_power_up;
    cmp_bit(standby, 1'b1, "no standby after power-up");
    cmp_bit(deepSleep, 1'b0, "asleep after power-up");
    cmp_bit(link.misoLine, 1'b1, "data line not released");
  endtask
  task automatic s_clear_flags;
    programErrorSet <= 1'b1;
    eraseErrorSet   <= 1'b1;
    @(posedge clk);
    programErrorSet <= 1'b0;
    eraseErrorSet   <= 1'b0;
    @(posedge clk);
    cmp_bit(programError, 1'b1, "program error not set");
    cmp_bit(eraseError, 1'b1, "erase error not set");
    cmd(8'h30);
    cmp_bit(programError, 1'b0, "program error kept");
    cmp_bit(eraseError, 1'b0, "erase error kept");
    cmd(8'h06);
    cmd(8'h30);
    cmp_bit(writeLatch, 1'b1, "latch changed by clear");
  endtask
  task automatic s_program;
    xfer({8'h42, 8'h00, 8'h13, 8'hFE, 8'hA5, 8'h5A, 8'h3C}, 0, 0);
    cmp_bit(writeInProgress, 1'b1, "program cycle not started");
    cmp_bit(writeLatch, 1'b0, "latch not cleared");
    cmd(8'hB9);
    cmp_bit(deepSleep, 1'b0, "sleep taken while programming");
    cmp_bit(writeInProgress, 1'b1, "cycle disturbed by sleep");
    xfer({8'hAB, 8'h00, 8'h00, 8'h00}, 1, GRD);
    expect_rx({8'hFF});
    wait_ready();
    xfer({8'h48, 8'h00, 8'h13, 8'hFE, 8'h00}, 4, GRD);
    expect_rx({8'hA5, 8'h5A, 8'h3C, 8'hFF});
  endtask
  task automatic s_lock_wide;
    lockBits     <= 2'h1;
    fourByteMode <= 1'b1;
    cmd(8'h06);
    xfer({8'h42, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00}, 0, GRD);
    cmp_bit(writeInProgress, 1'b0, "locked register programmed");
    xfer({8'h42, 8'h00, 8'h00, 8'h20, 8'h05, 8'h81}, 0, 0);
    cmp_bit(writeInProgress, 1'b1, "wide address program refused");
    wait_ready();
    xfer({8'h48, 8'h00, 8'h00, 8'h20, 8'h04, 8'h00}, 3, GRD);
    expect_rx({8'hFF, 8'h81, 8'hFF});
    xfer({8'h48, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00}, 1, GRD);
    expect_rx({8'h3C});
    lockBits     <= 2'h0;
    fourByteMode <= 1'b0;
  endtask
  task automatic s_sleep;
    xfer({8'hB9, 8'h00}, 0, GRD);
    cmp_bit(deepSleep, 1'b0, "sleep taken from long frame");
    cmd(8'hB9);
    cmp_bit(deepSleep, 1'b1, "sleep not entered");
    cmd(8'h06);
    cmp_bit(writeLatch, 1'b0, "latch set while asleep");
    xfer({8'h48, 8'h00, 8'h10, 8'h00, 8'h00}, 1, GRD);
    expect_rx({8'hFF});
    xfer({8'hAB}, 0, 10);
    cmp_bit(delayActive, 1'b1, "wake delay not running");
    cmd(8'h06);
    cmp_bit(writeLatch, 1'b0, "command taken in wake delay");
    cmp_bit(deepSleep, 1'b0, "wake not done");
    cmd(8'h06);
    cmp_bit(writeLatch, 1'b1, "command refused after wake");
  endtask
  task automatic s_identify;
    cmd(8'hB9);
    cmp_bit(deepSleep, 1'b1, "sleep not entered");
    xfer({8'hAB, 8'h00, 8'h00, 8'h00}, 3, GRD);
    expect_rx({ID, ID, ID});
    cmp_bit(deepSleep, 1'b0, "identify did not wake");
    cmd(8'hB9);
    cmp_bit(deepSleep, 1'b1, "sleep not entered before reset");
    cmd(8'h66);
    cmd(8'h99);
    cmp_bit(deepSleep, 1'b0, "soft reset did not wake");
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    miss("watchdog expired");
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    s_power_up();
    s_clear_flags();
    s_program();
    s_lock_wide();
    s_sleep();
    s_identify();
    close_out();
  end
endmodule
`default_nettype wire
